// [alsr_chan_if.sv]
// interface: one channel's raw measurement passed to the result formatter
`timescale 1ns/1ps
`default_nettype none
interface alsr_chan_if;
    logic [25:0] raw;         // 26-bit result buffer
    logic        analog_sat;  // modulator analog saturation during this result
    logic [15:0] result;      // presented 16-bit value
    logic        unscaled;    // set when result carries no shift

    modport fmt (
        input  raw,
        input  analog_sat,
        output result,
        output unscaled
    );
    modport user (
        output raw,
        output analog_sat,
        input  result,
        input  unscaled
    );
endinterface
`default_nettype wire

// [alsr_host_model.sv]
// partner model: host issuing reads and writes on the register port
`timescale 1ns/1ps
`default_nettype none
module alsr_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rd_data,
    output var logic        reg_rd_stb,
    output var logic        reg_wr_stb,
    output var logic [7:0]  reg_addr
);
    // ----------------------------------------
    // bus cycles, entered just after a falling edge
    // ----------------------------------------
    initial begin
        reg_rd_stb = 1'b0;
        reg_wr_stb = 1'b0;
        reg_addr   = 8'h00;
    end
    // idle address shows the inverse, so a stale copy cannot pass
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr   = a;
        reg_rd_stb = 1'b1;
        @(negedge core_clk);
        reg_rd_stb = 1'b0;
        reg_addr   = ~a;
        @(negedge core_clk);
        d = reg_rd_data;
    endtask
    task automatic wr(input logic [7:0] a);
        reg_addr   = a;
        reg_wr_stb = 1'b1;
        @(negedge core_clk);
        reg_wr_stb = 1'b0;
        reg_addr   = ~a;
    endtask
endmodule
`default_nettype wire

// [alsr_pkg.sv]
// package: register map, field positions and formats of the ambient light result readout
package alsr_pkg;
    // register addresses on the device register port
    localparam logic [7:0] ADDR_RESULT_FLAGS = 8'h94;
    localparam logic [7:0] ADDR_CH0_LOW      = 8'h95;
    localparam logic [7:0] ADDR_CH0_HIGH     = 8'h96;
    localparam logic [7:0] ADDR_CH1_LOW      = 8'h97;
    localparam logic [7:0] ADDR_CH1_HIGH     = 8'h98;
    localparam logic [7:0] ADDR_CH2_LOW      = 8'h99;
    localparam logic [7:0] ADDR_CH2_HIGH     = 8'h9A;
    localparam logic [7:0] ADDR_GAIN01       = 8'h9B;
    localparam logic [7:0] ADDR_GAIN2        = 8'h9C;
    localparam logic [7:0] ADDR_SAT_VALID    = 8'h9D;

    // result_flags field positions
    localparam int STEP_MSB      = 7;
    localparam int STEP_LSB      = 6;
    localparam int ASAT_CH0_BIT  = 5;
    localparam int ASAT_CH1_BIT  = 4;
    localparam int ASAT_CH2_BIT  = 3;
    localparam int UNSC_CH0_BIT  = 2;
    localparam int UNSC_CH1_BIT  = 1;
    localparam int UNSC_CH2_BIT  = 0;

    // saturation_valid_flags field positions
    localparam int FRESH_BIT     = 6;
    localparam int AOVF_BIT      = 4;
    localparam int FOVF_BIT      = 3;
    localparam int MOD2_BIT      = 2;
    localparam int MOD1_BIT      = 1;
    localparam int MOD0_BIT      = 0;

    // gain report field positions
    localparam int GAIN_HI_LSB   = 4;
    localparam int GAIN_LO_LSB   = 0;

    // formats and special values
    localparam int BUF_W         = 26;
    localparam int RES_W         = 16;
    localparam int GAIN_W        = 4;
    localparam int SHIFT_W       = 4;
    localparam int TOP_W         = 5;
    localparam logic [15:0] RES_OVER_RANGE = 16'hFFFE;
    localparam logic [15:0] RES_ANALOG_SAT = 16'hFFFF;
    localparam logic [7:0]  REG_RESET      = 8'h00;
endpackage

// [alsr_readout.sv]
// module: ambient light result and status register readout
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] status bits 7:6 give sequencer step
// [R2] bits 5:3 flag channel analog saturation
// [R3] bits 2:0 set means result is unscaled
// [R4] data refresh only on status register read
// [R5] 16-bit results, low byte at lower address
// [R6] all three results from one cycle
// [R7] low/high pair always from one result
// [R8] result selected from 26-bit buffer by settings
// [R9] over top bit range presents 0xFFFE
// [R10] analog saturation presents 0xFFFF
// [R11] gain report: channel 1 high, channel 0 low
// [R12] channel 2 gain low nibble, upper zero
// [R13] fresh flag after cycle since enable/read
// [R14] ambient counter overflow flag in bit 4
// [R15] flicker counter overflow flag in bit 3
// [R16] modulator analog overload flags bits 2:0
// [R17] overload raises modulator irq flag
// [R18] snapshot taken at status read, held
// [R19] registers reset to zero, writes ignored
module alsr_readout #(
    parameter int BUF_W  = 26,
    parameter int GAIN_W = 4
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // register port from the serial interface logic
    input  wire logic              reg_rd_stb,
    input  wire logic              reg_wr_stb,
    input  wire logic [7:0]        reg_addr,
    output logic [7:0]             reg_rd_data,
    // measurement side
    input  wire logic              ambient_measure_enable,
    input  wire logic              cycle_done,
    input  wire logic [1:0]        cycle_step,
    input  wire logic [BUF_W-1:0]  ch0_raw,
    input  wire logic [BUF_W-1:0]  ch1_raw,
    input  wire logic [BUF_W-1:0]  ch2_raw,
    input  wire logic [GAIN_W-1:0] ch0_gain,
    input  wire logic [GAIN_W-1:0] ch1_gain,
    input  wire logic [GAIN_W-1:0] ch2_gain,
    input  wire logic [2:0]        mod_overload_evt,
    input  wire logic              ambient_ovf_evt,
    input  wire logic              flicker_ovf_evt,
    input  wire logic [3:0]        result_shift_setting,
    input  wire logic [4:0]        result_top_bit_select,
    output logic                   modulator_overload_irq
);
    // ---------------------------------------------------------------
    // latest completed cycle
    // ---------------------------------------------------------------
    // the formatter works on the values of the most recent completed
    // cycle, so all three channels always share one integration cycle
    logic [BUF_W-1:0]  raw_r [3];
    logic [2:0]        cyc_asat_r;
    logic [1:0]        cyc_step_r;
    logic [GAIN_W-1:0] cyc_gain_r [3];
    logic [2:0]        mod_sat_accum_r;
    logic              cyc_seen_r;

    // capture every channel together at the end of a cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                raw_r[i]      <= '0;
                cyc_gain_r[i] <= '0;
            end
            cyc_asat_r <= 3'h0;
            cyc_step_r <= 2'h0;
            cyc_seen_r <= 1'b0;
        end else if (cycle_done) begin
            cyc_seen_r    <= 1'b1;
            raw_r[0]      <= ch0_raw;                        // [R6]
            raw_r[1]      <= ch1_raw;
            raw_r[2]      <= ch2_raw;
            cyc_gain_r[0] <= ch0_gain;
            cyc_gain_r[1] <= ch1_gain;
            cyc_gain_r[2] <= ch2_gain;
            cyc_asat_r    <= mod_sat_accum_r | mod_overload_evt;
            cyc_step_r    <= cycle_step;
        end
    end

    // overload seen at any time during the running cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_sat_accum_r <= 3'h0;
        end else if (cycle_done) begin
            mod_sat_accum_r <= 3'h0;
        end else begin
            mod_sat_accum_r <= mod_sat_accum_r | mod_overload_evt;
        end
    end

    // ---------------------------------------------------------------
    // formatting
    // ---------------------------------------------------------------
    alsr_chan_if ch_if [3] ();
    logic [15:0] fmt_res [3];
    logic [2:0]  fmt_unsc;

    for (genvar g = 0; g < 3; g++) begin : g_fmt
        assign ch_if[g].raw        = raw_r[g][25:0];
        assign ch_if[g].analog_sat = cyc_asat_r[g];
        assign fmt_res[g]          = ch_if[g].result;
        assign fmt_unsc[g]         = ch_if[g].unscaled;
        alsr_result_fmt u_fmt (
            .result_shift_setting  (result_shift_setting),
            .result_top_bit_select (result_top_bit_select),
            .ch                    (ch_if[g])
        );
    end

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    logic status_rd;
    assign status_rd = reg_rd_stb && (reg_addr == alsr_pkg::ADDR_RESULT_FLAGS);

    // an empty buffer after reset would format as unscaled; the flags
    // stay at their reset value of zero until a cycle has completed
    logic [2:0] unsc_shown;
    assign unsc_shown = fmt_unsc & {3{cyc_seen_r}};                 // [R19]

    // ---------------------------------------------------------------
    // snapshot registers
    // ---------------------------------------------------------------
    logic [15:0]       snap_res_r [3];
    logic [2:0]        snap_asat_r;
    logic [2:0]        snap_unsc_r;
    logic [1:0]        snap_step_r;
    logic [GAIN_W-1:0] snap_gain_r [3];

    // refreshed only by the status read; held until the next one, so
    // a low/high byte pair read later can never straddle two results
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                snap_res_r[i]  <= 16'h0000;              // [R19]
                snap_gain_r[i] <= '0;
            end
            snap_asat_r <= 3'h0;
            snap_unsc_r <= 3'h0;
            snap_step_r <= 2'h0;
        end else if (status_rd) begin                    // [R4] [R18]
            for (int i = 0; i < 3; i++) begin
                snap_res_r[i]  <= fmt_res[i];            // [R7]
                snap_gain_r[i] <= cyc_gain_r[i];
            end
            snap_asat_r <= cyc_asat_r;                   // [R2]
            snap_unsc_r <= unsc_shown;                   // [R3]
            snap_step_r <= cyc_step_r;                   // [R1]
        end
    end

    // ---------------------------------------------------------------
    // sticky status flags
    // ---------------------------------------------------------------
    logic       fresh_r;
    logic       enable_d_r;
    logic       aovf_r;
    logic       fovf_r;
    logic [2:0] mod_ovl_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_d_r <= 1'b0;
        end else begin
            enable_d_r <= ambient_measure_enable;
        end
    end

    // a cycle end with ambient_measure_enable high in the same clock as the status read wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fresh_r <= 1'b0;
        end else if (cycle_done && ambient_measure_enable) begin
            fresh_r <= 1'b1;                             // [R13]
        end else if (status_rd || (ambient_measure_enable && !enable_d_r)) begin
            fresh_r <= 1'b0;                             // [R13]
        end
    end

    // overflow and overload flags collect the measurement events and stay set;
    // they reload from the current events only when ambient_measure_enable rises
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aovf_r    <= 1'b0;
            fovf_r    <= 1'b0;
            mod_ovl_r <= 3'h0;
        end else if (ambient_measure_enable && !enable_d_r) begin
            aovf_r    <= ambient_ovf_evt;
            fovf_r    <= flicker_ovf_evt;
            mod_ovl_r <= mod_overload_evt;
        end else begin
            aovf_r    <= aovf_r | ambient_ovf_evt;       // [R14]
            fovf_r    <= fovf_r | flicker_ovf_evt;       // [R15]
            mod_ovl_r <= mod_ovl_r | mod_overload_evt;   // [R16]
        end
    end

    // interrupt flag is not held; it follows the events one clock later and is
    // high for each clock with a modulator overload or ambient overflow event
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modulator_overload_irq <= 1'b0;
        end else begin
            modulator_overload_irq <= (|mod_overload_evt) | ambient_ovf_evt;   // [R17]
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    logic [7:0] rd_nxt;

    // writes to this range are ignored; unmapped addresses read zero
    always_comb begin
        rd_nxt = alsr_pkg::REG_RESET;                    // [R19]
        case (reg_addr)
            alsr_pkg::ADDR_RESULT_FLAGS: begin
                rd_nxt[alsr_pkg::STEP_MSB:alsr_pkg::STEP_LSB] = cyc_step_r;
                rd_nxt[alsr_pkg::ASAT_CH0_BIT] = cyc_asat_r[0];
                rd_nxt[alsr_pkg::ASAT_CH1_BIT] = cyc_asat_r[1];
                rd_nxt[alsr_pkg::ASAT_CH2_BIT] = cyc_asat_r[2];
                rd_nxt[alsr_pkg::UNSC_CH0_BIT] = unsc_shown[0];
                rd_nxt[alsr_pkg::UNSC_CH1_BIT] = unsc_shown[1];
                rd_nxt[alsr_pkg::UNSC_CH2_BIT] = unsc_shown[2];
            end
            alsr_pkg::ADDR_CH0_LOW:  rd_nxt = snap_res_r[0][7:0];    // [R5]
            alsr_pkg::ADDR_CH0_HIGH: rd_nxt = snap_res_r[0][15:8];
            alsr_pkg::ADDR_CH1_LOW:  rd_nxt = snap_res_r[1][7:0];
            alsr_pkg::ADDR_CH1_HIGH: rd_nxt = snap_res_r[1][15:8];
            alsr_pkg::ADDR_CH2_LOW:  rd_nxt = snap_res_r[2][7:0];
            alsr_pkg::ADDR_CH2_HIGH: rd_nxt = snap_res_r[2][15:8];
            alsr_pkg::ADDR_GAIN01: begin
                rd_nxt[alsr_pkg::GAIN_HI_LSB +: 4] = snap_gain_r[1][3:0];   // [R11]
                rd_nxt[alsr_pkg::GAIN_LO_LSB +: 4] = snap_gain_r[0][3:0];
            end
            alsr_pkg::ADDR_GAIN2: begin
                rd_nxt[alsr_pkg::GAIN_LO_LSB +: 4] = snap_gain_r[2][3:0];   // [R12]
            end
            alsr_pkg::ADDR_SAT_VALID: begin
                rd_nxt[alsr_pkg::FRESH_BIT] = fresh_r;
                rd_nxt[alsr_pkg::AOVF_BIT]  = aovf_r;
                rd_nxt[alsr_pkg::FOVF_BIT]  = fovf_r;
                rd_nxt[alsr_pkg::MOD2_BIT]  = mod_ovl_r[2];
                rd_nxt[alsr_pkg::MOD1_BIT]  = mod_ovl_r[1];
                rd_nxt[alsr_pkg::MOD0_BIT]  = mod_ovl_r[0];
            end
            default: rd_nxt = alsr_pkg::REG_RESET;
        endcase
    end

    // read data registered on the strobe and held until the next read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= alsr_pkg::REG_RESET;
        end else if (reg_rd_stb) begin
            reg_rd_data <= rd_nxt;
        end
    end
endmodule
`default_nettype wire

// [alsr_readout_assertions.sv]
// checker: port-level assertions for the result readout
`timescale 1ns/1ps
`default_nettype none
module alsr_readout_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       reg_rd_stb,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rd_data,
    input wire logic       ambient_measure_enable,
    input wire logic       cycle_done,
    input wire logic [2:0] mod_overload_evt,
    input wire logic       ambient_ovf_evt,
    input wire logic       modulator_overload_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // read port and flags
    // ----------------------------------------
    property p_hold; !reg_rd_stb |=> $stable(reg_rd_data); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; reg_rd_stb && (reg_addr < 8'h94 || reg_addr > 8'h9D) |=> !reg_rd_data; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    property p_rst; $rose(rst_n) |-> reg_rd_data == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("data not zero at reset");
    property p_g2; reg_rd_stb && reg_addr == 8'h9C |=> reg_rd_data[7:4] == 4'h0; endproperty
    a_g2: assert property (p_g2) else $error("gain upper bits set");
    // reserved bits of the flag register must never show
    property p_rsv; reg_rd_stb && reg_addr == 8'h9D |=> !reg_rd_data[7] && !reg_rd_data[5]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_fr; ambient_measure_enable && cycle_done ##1 reg_rd_stb && reg_addr == 8'h9D
        |=> reg_rd_data[6]; endproperty
    a_fr: assert property (p_fr) else $error("fresh flag missing");
    property p_frc; reg_rd_stb && reg_addr == 8'h94 && !cycle_done ##1 !cycle_done
        ##1 reg_rd_stb && reg_addr == 8'h9D && !cycle_done |=> !reg_rd_data[6]; endproperty
    a_frc: assert property (p_frc) else $error("fresh flag not cleared");
    property p_ovf; ambient_ovf_evt && $stable(ambient_measure_enable) ##1 reg_rd_stb
        && reg_addr == 8'h9D && ambient_measure_enable |=> reg_rd_data[4]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag missing");
    property p_irq; (|mod_overload_evt) || ambient_ovf_evt |=> modulator_overload_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_irq0; !(|mod_overload_evt) && !ambient_ovf_evt |=> !modulator_overload_irq; endproperty
    a_irq0: assert property (p_irq0) else $error("irq without cause");
endmodule
bind alsr_readout alsr_readout_checker u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
    .reg_rd_data(reg_rd_data), .ambient_measure_enable(ambient_measure_enable),
    .cycle_done(cycle_done), .mod_overload_evt(mod_overload_evt),
    .ambient_ovf_evt(ambient_ovf_evt), .modulator_overload_irq(modulator_overload_irq)
);
`default_nettype wire

// [alsr_readout_tb.sv]
// testbench: scenarios for the ambient light result readout
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ambient_light_result_readout_tb_top;
    logic        core_clk   = 1'b0;
    logic        rst_n      = 1'b0;
    logic        reg_rd_stb;
    logic        reg_wr_stb;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_rd_data;
    logic        meas_en    = 1'b0;
    logic        cycle_done = 1'b0;
    logic [1:0]  step       = 2'h0;
    logic [25:0] raw [3]    = '{default: 26'h0};
    logic [3:0]  gain [3]   = '{default: 4'h0};
    logic [2:0]  mod_evt    = 3'h0;
    logic        aovf       = 1'b0;
    logic        fovf       = 1'b0;
    logic [3:0]  shift      = 4'h0;
    logic [4:0]  top        = 5'h10;
    logic        irq;
    int          n_fail     = 0;
    int          tests_run  = 0;
    int          cycles     = 0;
    // ----------------------------------------
    // design, host and clocking
    // ----------------------------------------
    alsr_readout dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_rd_stb(reg_rd_stb), .reg_wr_stb(reg_wr_stb),
        .reg_addr(reg_addr), .reg_rd_data(reg_rd_data), .ambient_measure_enable(meas_en),
        .cycle_done(cycle_done), .cycle_step(step), .ch0_raw(raw[0]), .ch1_raw(raw[1]),
        .ch2_raw(raw[2]), .ch0_gain(gain[0]), .ch1_gain(gain[1]), .ch2_gain(gain[2]),
        .mod_overload_evt(mod_evt), .ambient_ovf_evt(aovf), .flicker_ovf_evt(fovf),
        .result_shift_setting(shift), .result_top_bit_select(top),
        .modulator_overload_irq(irq)
    );
    alsr_host_model u_host (
        .core_clk(core_clk), .reg_rd_data(reg_rd_data), .reg_rd_stb(reg_rd_stb),
        .reg_wr_stb(reg_wr_stb), .reg_addr(reg_addr)
    );
    initial forever #5 core_clk = ~core_clk;
    // a hang is cut short well beyond the roughly 110 cycles needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic rx(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic meas(input logic [1:0] st);
        step       = st;
        cycle_done = 1'b1;
        @(negedge core_clk);
        cycle_done = 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int a = 8'h93; a <= 8'hA0; a++) begin
            u_host.wr(8'(a));
            rx(8'(a), 8'h00);
        end
        $display("reset test done");
    endtask
    // plain, shifted and over-range channels in one cycle
    task automatic t_format();
        meas_en = 1'b1;
        shift   = 4'h4;
        raw     = '{26'h00000AB, 26'h0012345, 26'h3FFFFFF};
        gain    = '{4'h3, 4'h5, 4'h9};
        @(negedge core_clk);
        meas(2'h2);
        rx(8'h9D, 8'h40);
        rx(8'h94, 8'h84);
        rx(8'h95, 8'hAB);
        rx(8'h96, 8'h00);
        rx(8'h97, 8'h34);
        rx(8'h98, 8'h12);
        rx(8'h99, 8'hFE);
        rx(8'h9A, 8'hFF);
        rx(8'h9B, 8'h53);
        rx(8'h9C, 8'h09);
        rx(8'h9D, 8'h00);
        $display("format test done");
    endtask
    // a new cycle stays hidden until the status read
    task automatic t_hold();
        raw  = '{26'h0000011, 26'h0000022, 26'h0000033};
        gain = '{4'h1, 4'h2, 4'h4};
        meas(2'h1);
        rx(8'h95, 8'hAB);
        rx(8'h9B, 8'h53);
        rx(8'h94, 8'h47);
        rx(8'h95, 8'h11);
        rx(8'h97, 8'h22);
        rx(8'h99, 8'h33);
        rx(8'h9C, 8'h04);
        $display("hold test done");
    endtask
    task automatic t_sat();
        mod_evt = 3'b010;
        raw     = '{26'h0000001, 26'h0000002, 26'h0000003};
        meas(2'h3);
        mod_evt = 3'b000;
        `CHK(irq, 1'b1)
        aovf = 1'b1;
        fovf = 1'b1;
        @(negedge core_clk);
        aovf = 1'b0;
        fovf = 1'b0;
        rx(8'h9D, 8'h5A);
        rx(8'h94, 8'hD7);
        rx(8'h97, 8'hFF);
        rx(8'h98, 8'hFF);
        rx(8'h95, 8'h01);
        meas_en = 1'b0;
        @(negedge core_clk);
        meas_en = 1'b1;
        @(negedge core_clk);
        rx(8'h9D, 8'h00);
        // a low top bit setting pushes a small channel over range
        top = 5'h01;
        raw = '{26'h0000004, 26'h0000001, 26'h0000001};
        meas(2'h0);
        rx(8'h94, 8'h07);
        rx(8'h95, 8'hFE);
        rx(8'h96, 8'hFF);
        rx(8'h97, 8'h01);
        $display("saturation test done");
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        t_reset();
        t_format();
        t_hold();
        t_sat();
        summarize();
    end
endmodule
`default_nettype wire

// [alsr_result_fmt.sv]
// module: selects a 16-bit channel result from the 26-bit result buffer
`timescale 1ns/1ps
`default_nettype none
module alsr_result_fmt (
    input  wire logic [3:0] result_shift_setting,
    input  wire logic [4:0] result_top_bit_select,
    alsr_chan_if.fmt        ch
);
    // ---------------------------------------------------------------
    // selection
    // ---------------------------------------------------------------
    logic [25:0] shifted;
    logic        over_top;
    logic        need_shift;

    // shift only when the raw value does not fit 16 bits unshifted;
    // small results keep full resolution and report unscaled
    always_comb begin
        need_shift = (ch.raw[25:16] != 10'h000);
        shifted    = need_shift ? (ch.raw >> result_shift_setting) : ch.raw;
        over_top   = ((shifted >> result_top_bit_select) > 26'h0000001)
                     || (shifted[25:16] != 10'h000);
    end

    // analog saturation outranks the range check
    always_comb begin
        if (ch.analog_sat) begin
            ch.result = alsr_pkg::RES_ANALOG_SAT;   // [R10]
        end else if (over_top) begin
            ch.result = alsr_pkg::RES_OVER_RANGE;   // [R9]
        end else begin
            ch.result = shifted[15:0];              // [R8]
        end
        ch.unscaled = !need_shift || (result_shift_setting == 4'h0);   // [R3]
    end
endmodule
`default_nettype wire
